// File: rgbs_cfg.svh
`ifndef RGBS_CFG_SVH
`define RGBS_CFG_SVH

`define RGBS_CLK_KHZ 250000
`define RGBS_OFS_DELAY_MS 10
`define RGBS_BIAS_DELAY_MS 145
`define RGBS_PD_DELAY_MS 1
`define RGBS_TMR_W 26
`define RGBS_CODE_W 10

`define RGBS_ADDR_CODE1_LO 7'h00
`define RGBS_ADDR_CODE1_HI 7'h01
`define RGBS_ADDR_CODE2_LO 7'h02
`define RGBS_ADDR_CODE2_HI 7'h03
`define RGBS_ADDR_CODE3_LO 7'h04
`define RGBS_ADDR_CODE3_HI 7'h05
`define RGBS_ADDR_CTRL 7'h08
`define RGBS_ADDR_DEAD 7'h0b
`define RGBS_ADDR_MASK 7'h0d
`define RGBS_ADDR_STATUS 7'h0e

`define RGBS_RST_DEAD 8'h04
`define RGBS_RST_MASK 8'h00
`define RGBS_RST_CTRL 3'h0
`define RGBS_FRAME_BITS 5'h10
`define RGBS_CMD_BITS 5'h08

`endif

// File: rgbs_pkg.sv
`include "rgbs_cfg.svh"
package rgbs_pkg;
  typedef enum logic [2:0] {
    PWR_OFF = 3'h0,
    PWR_INIT = 3'h1,
    PWR_BIAS_WAIT = 3'h3,
    PWR_ON = 3'h2,
    PWR_DOWN = 3'h6,
    PWR_FAULT = 3'h7
  } pwr_e;

  typedef struct packed {
    logic offset_rail;
    logic bias_rail;
    logic mirror_reset_rail;
  } rails_s;

  typedef struct packed {
    logic clk;
    logic cs_n;
    logic din;
  } spi_pins_s;

  typedef struct packed {
    pwr_e st;
    logic [`RGBS_TMR_W-1:0] tmr;
    logic mirror_init;
    rails_s rails;
    spi_pins_s spi1;
    spi_pins_s spi2;
    logic clk_d;
    logic [2:0] flt1;
    logic [2:0] flt2;
    logic [1:0] sel1;
    logic [1:0] sel2;
    logic req1;
    logic req2;
    logic [4:0] bitcnt;
    logic [15:0] sh;
    logic [7:0] tx;
    logic dout;
    logic dout_oe;
    logic [2:0][`RGBS_CODE_W-1:0] code;
    logic [2:0] swctl;
    logic [7:0] dead;
    logic [7:0] mask;
    logic [2:0] fault;
    logic [1:0] target;
    logic [2:0] sw;
    logic [7:0] bbm_cnt;
    logic bbm_busy;
    logic [`RGBS_CODE_W-1:0] code_out;
    logic code_valid;
  } state_s;
endpackage : rgbs_pkg

// File: rgb_strobe_power_sequencer.sv
`timescale 1ns/1ps
`include "rgbs_cfg.svh"
module rgb_strobe_power_sequencer #(
  parameter int unsigned OFS_DELAY_CYC = `RGBS_OFS_DELAY_MS * `RGBS_CLK_KHZ,
  parameter int unsigned BIAS_DELAY_CYC = `RGBS_BIAS_DELAY_MS * `RGBS_CLK_KHZ,
  parameter int unsigned PD_DELAY_CYC = `RGBS_PD_DELAY_MS * `RGBS_CLK_KHZ
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic projection_power_request_i,
  input wire logic [1:0] colour_select_i,
  input wire logic [2:0] rail_fault_i,
  input wire logic spi_clk_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_din_i,
  output logic spi_dout_o,
  output logic spi_dout_oe_o,
  output logic mirror_init_o,
  output rgbs_pkg::rails_s rails_o,
  output logic led_driver_enable_o,
  output logic first_channel_switch_o,
  output logic second_channel_switch_o,
  output logic third_channel_switch_o,
  output logic [`RGBS_CODE_W-1:0] current_code_o,
  output logic current_code_valid_o,
  output logic interrupt_out_n_o
);
  import rgbs_pkg::*;

  localparam logic [`RGBS_TMR_W-1:0] OFS_T = `RGBS_TMR_W'(OFS_DELAY_CYC);
  localparam logic [`RGBS_TMR_W-1:0] BIAS_T = `RGBS_TMR_W'(BIAS_DELAY_CYC);
  localparam logic [`RGBS_TMR_W-1:0] PD_T = `RGBS_TMR_W'(PD_DELAY_CYC);

  state_s s;
  state_s next_s;

  logic [2:0] want;
  logic [2:0] flt_set;
  logic [7:0] rdata;
  logic clk_rise;
  logic clk_fall;

  always_comb begin
    next_s = s;
    // Pins from other domains pass two flops before anything reads them
    next_s.spi1 = '{clk: spi_clk_i, cs_n: spi_cs_n_i, din: spi_din_i};
    next_s.spi2 = s.spi1;
    next_s.clk_d = s.spi2.clk;
    next_s.flt1 = rail_fault_i;
    next_s.flt2 = s.flt1;
    next_s.sel1 = colour_select_i;
    next_s.sel2 = s.sel1;
    next_s.req1 = projection_power_request_i;
    next_s.req2 = s.req1;
    next_s.mirror_init = 1'b0;

    clk_rise = s.spi2.clk & ~s.clk_d;
    clk_fall = ~s.spi2.clk & s.clk_d;

    unique case (s.sh[6:0])
      `RGBS_ADDR_CODE1_LO: rdata = s.code[0][7:0];
      `RGBS_ADDR_CODE1_HI: rdata = {6'h00, s.code[0][9:8]};
      `RGBS_ADDR_CODE2_LO: rdata = s.code[1][7:0];
      `RGBS_ADDR_CODE2_HI: rdata = {6'h00, s.code[1][9:8]};
      `RGBS_ADDR_CODE3_LO: rdata = s.code[2][7:0];
      `RGBS_ADDR_CODE3_HI: rdata = {6'h00, s.code[2][9:8]};
      `RGBS_ADDR_CTRL: rdata = {5'h00, s.swctl};
      `RGBS_ADDR_DEAD: rdata = s.dead;
      `RGBS_ADDR_MASK: rdata = s.mask;
      `RGBS_ADDR_STATUS: rdata = {(s.st == PWR_ON), 1'b0, s.rails, s.fault};
      default: rdata = 8'h00;
    endcase

    // Fault flags latch while the rail stands enabled
    flt_set = s.flt2 & {s.rails.offset_rail, s.rails.bias_rail, s.rails.mirror_reset_rail};

    // SPI slave: sample on rising edge, present data on falling edge
    if (s.spi2.cs_n) begin
      next_s.bitcnt = 5'h00;
      next_s.dout_oe = 1'b0;
      next_s.dout = 1'b0;
    end else begin
      next_s.dout_oe = 1'b1;
      if (clk_rise && s.bitcnt != `RGBS_FRAME_BITS) begin
        next_s.sh = {s.sh[14:0], s.spi2.din};
        next_s.bitcnt = s.bitcnt + 5'h01;
      end
      // Bit 7 leaves on the fall after the eighth rise; the word is taken once per frame
      if (clk_fall && s.bitcnt == `RGBS_CMD_BITS) begin
        next_s.dout = rdata[7] & ~s.sh[7];
        next_s.tx = s.sh[7] ? 8'h00 : {rdata[6:0], 1'b0};
      end else if (clk_fall && s.bitcnt > `RGBS_CMD_BITS) begin
        next_s.dout = s.tx[7];
        next_s.tx = {s.tx[6:0], 1'b0};
      end
    end
    if (s.spi2.cs_n || s.bitcnt < `RGBS_CMD_BITS) begin
      next_s.tx = 8'h00;
    end

    // Write commits on the last bit; a clear in the same cycle loses to a new fault
    next_s.fault = s.fault | flt_set;
    if (!s.spi2.cs_n && clk_rise && s.bitcnt == `RGBS_FRAME_BITS - 5'h01 && s.sh[14]) begin
      unique case (s.sh[13:7])
        `RGBS_ADDR_CODE1_LO: next_s.code[0][7:0] = {s.sh[6:0], s.spi2.din};
        `RGBS_ADDR_CODE1_HI: next_s.code[0][9:8] = {s.sh[0], s.spi2.din};
        `RGBS_ADDR_CODE2_LO: next_s.code[1][7:0] = {s.sh[6:0], s.spi2.din};
        `RGBS_ADDR_CODE2_HI: next_s.code[1][9:8] = {s.sh[0], s.spi2.din};
        `RGBS_ADDR_CODE3_LO: next_s.code[2][7:0] = {s.sh[6:0], s.spi2.din};
        `RGBS_ADDR_CODE3_HI: next_s.code[2][9:8] = {s.sh[0], s.spi2.din};
        `RGBS_ADDR_CTRL: next_s.swctl = {s.sh[1:0], s.spi2.din};
        `RGBS_ADDR_DEAD: next_s.dead = {s.sh[6:0], s.spi2.din};
        `RGBS_ADDR_MASK: next_s.mask = {s.sh[6:0], s.spi2.din};
        `RGBS_ADDR_STATUS: next_s.fault = (s.fault & ~{s.sh[1:0], s.spi2.din}) | flt_set;
        default: ;
      endcase
    end

    // Power sequencing
    if (s.tmr != '0) begin
      next_s.tmr = s.tmr - `RGBS_TMR_W'(1);
    end
    unique case (s.st)
      PWR_OFF: begin
        next_s.rails = '0;
        if (s.req2) begin
          next_s.mirror_init = 1'b1;
          next_s.tmr = OFS_T;
          next_s.st = PWR_INIT;
        end
      end
      PWR_INIT: begin
        if (s.tmr <= `RGBS_TMR_W'(1)) begin
          next_s.rails.offset_rail = 1'b1;
          next_s.tmr = BIAS_T;
          next_s.st = PWR_BIAS_WAIT;
        end
      end
      PWR_BIAS_WAIT: begin
        if (s.tmr <= `RGBS_TMR_W'(1)) begin
          next_s.rails.bias_rail = 1'b1;
          next_s.rails.mirror_reset_rail = 1'b1;
          next_s.st = PWR_ON;
        end
      end
      PWR_ON: ;
      PWR_DOWN: begin
        next_s.rails.bias_rail = 1'b0;
        next_s.rails.mirror_reset_rail = 1'b0;
        if (s.tmr <= `RGBS_TMR_W'(1)) begin
          next_s.rails.offset_rail = 1'b0;
          next_s.st = PWR_OFF;
        end
      end
      PWR_FAULT: begin
        next_s.rails = '0;
        if (!s.req2) begin
          next_s.st = PWR_OFF;
        end
      end
      default: begin
        next_s.rails = '0;
        next_s.st = PWR_OFF;
      end
    endcase
    if (!s.req2 && (s.st == PWR_INIT || s.st == PWR_BIAS_WAIT || s.st == PWR_ON)) begin
      next_s.tmr = PD_T;
      next_s.st = PWR_DOWN;
    end
    // A fault overrides every other step and drops all rails in one cycle
    if (flt_set != 3'h0 && s.st != PWR_OFF && s.st != PWR_FAULT) begin
      next_s.rails = '0;
      next_s.tmr = '0;
      next_s.st = PWR_FAULT;
    end

    // Strobe decoder
    unique case (s.sel2)
      2'h0: want = 3'h0;
      2'h1: want = 3'h1;
      2'h2: want = 3'h2;
      2'h3: want = 3'h4;
    endcase
    if (s.st != PWR_ON) begin
      // Switches forced open until every rail is up
      next_s.sw = 3'h0;
      next_s.target = 2'h0;
      next_s.bbm_busy = 1'b0;
      next_s.bbm_cnt = 8'h00;
      next_s.code_valid = 1'b0;
    end else if (s.sel2 != s.target) begin
      // A change during dead time restarts it rather than closing early
      next_s.target = s.sel2;
      next_s.sw = s.sw & want & s.swctl;
      next_s.bbm_cnt = (s.dead == 8'h00) ? 8'h01 : s.dead;
      next_s.bbm_busy = 1'b1;
      next_s.code_valid = 1'b0;
    end else if (s.bbm_busy) begin
      next_s.bbm_cnt = s.bbm_cnt - 8'h01;
      if (s.bbm_cnt <= 8'h01) begin
        next_s.bbm_busy = 1'b0;
        next_s.sw = want;
        next_s.code_valid = (s.target != 2'h0);
        next_s.code_out = (s.target == 2'h0) ? '0 : s.code[s.target - 2'h1];
      end
    end else if (s.code_valid) begin
      next_s.code_out = s.code[s.target - 2'h1];
    end
  end

  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      s <= '0;
      s.st <= PWR_OFF;
      s.spi1 <= '{clk: 1'b0, cs_n: 1'b1, din: 1'b0};
      s.spi2 <= '{clk: 1'b0, cs_n: 1'b1, din: 1'b0};
      s.swctl <= `RGBS_RST_CTRL;
      s.dead <= `RGBS_RST_DEAD;
      s.mask <= `RGBS_RST_MASK;
    end else begin
      s <= next_s;
    end
  end

  assign spi_dout_o = s.dout;
  assign spi_dout_oe_o = s.dout_oe;
  assign mirror_init_o = s.mirror_init;
  assign rails_o = s.rails;
  assign led_driver_enable_o = (s.st == PWR_ON);
  assign first_channel_switch_o = s.sw[0];
  assign second_channel_switch_o = s.sw[1];
  assign third_channel_switch_o = s.sw[2];
  assign current_code_o = s.code_out;
  assign current_code_valid_o = s.code_valid;
  // Masking touches only this pin; the shutdown above never looks at the mask
  assign interrupt_out_n_o = ~|(s.fault & s.mask[2:0] ^ s.fault);
endmodule : rgb_strobe_power_sequencer

// File: rgbs_chk.sv
`timescale 1ns/1ps
module rgbs_chk #(
  parameter int unsigned OFS_DELAY_CYC = 20,
  parameter int unsigned BIAS_DELAY_CYC = 40,
  parameter int unsigned PD_DELAY_CYC = 10
) (
  input wire logic ref_clk_i,
  input wire logic resetn_i,
  input wire logic [2:0] rail_fault_i,
  input wire logic mirror_init_o,
  input wire rgbs_pkg::rails_s rails_o,
  input wire logic led_driver_enable_o,
  input wire logic first_channel_switch_o,
  input wire logic second_channel_switch_o,
  input wire logic third_channel_switch_o,
  input wire logic current_code_valid_o,
  input wire logic interrupt_out_n_o
);
  import rgbs_pkg::*;
  logic [2:0] sw;
  assign sw = {third_channel_switch_o, second_channel_switch_o, first_channel_switch_o};
  // Cycles spent with only the offset rail up
  int unsigned ofs_cnt;
  always_ff @(posedge ref_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ofs_cnt <= 32'h0;
    end else if (rails_o.offset_rail && !rails_o.bias_rail) begin
      ofs_cnt <= ofs_cnt + 32'h1;
    end else begin
      ofs_cnt <= 32'h0;
    end
  end
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!resetn_i);
  // Test values never set a dead time below 4
  sequence s_broken;
    (sw == 3'h0) [*3];
  endsequence
  a_led_gated: assert property (led_driver_enable_o |-> rails_o == 3'h7)
    else $error("led driver on with a rail off");
  a_init_offset: assert property (mirror_init_o |-> ##[1:30] rails_o.offset_rail)
    else $error("offset rail late after init");
  a_bias_wait: assert property ($rose(rails_o.offset_rail) |-> !rails_o.bias_rail [*8])
    else $error("bias rail too early");
  a_bias_delay: assert property ($rose(rails_o.bias_rail) |-> ofs_cnt == BIAS_DELAY_CYC)
    else $error("bias rail delay wrong");
  a_bias_order: assert property ($rose(rails_o.bias_rail) |-> rails_o == 3'h7)
    else $error("bias and reset rails out of order");
  a_normal_down: assert property ($fell(rails_o.bias_rail) && rails_o.offset_rail
    |-> rails_o.offset_rail [*8])
    else $error("offset rail dropped early");
  a_fault_drop: assert property (rails_o == 3'h7 && rail_fault_i != 3'h0
    |-> ##[1:5] rails_o == 3'h0)
    else $error("rails not discharged on fault");
  a_dead_gap: assert property ($fell(|sw) |-> s_broken)
    else $error("dead time too short");
  a_make_clean: assert property ((sw & ~$past(sw)) != 3'h0 |-> $past(sw) == 3'h0)
    else $error("switch made before break");
  a_one_switch: assert property ($rose(current_code_valid_o) |-> $onehot(sw))
    else $error("code valid without one switch");
  a_irq_cause: assert property ($fell(interrupt_out_n_o) |-> ##[0:2] rails_o == 3'h0)
    else $error("interrupt without fault shutdown");
endmodule : rgbs_chk
bind rgb_strobe_power_sequencer rgbs_chk #(.OFS_DELAY_CYC(OFS_DELAY_CYC),
  .BIAS_DELAY_CYC(BIAS_DELAY_CYC), .PD_DELAY_CYC(PD_DELAY_CYC)) rgbs_chk_inst (
  .ref_clk_i, .resetn_i, .rail_fault_i, .mirror_init_o, .rails_o, .led_driver_enable_o,
  .first_channel_switch_o, .second_channel_switch_o, .third_channel_switch_o,
  .current_code_valid_o, .interrupt_out_n_o);

// File: rgbs_ctrl_model.sv
`timescale 1ns/1ps
module rgbs_ctrl_model (
  input wire logic clk_i,
  input wire logic step_i,
  input wire logic blank_i,
  input wire logic pwr_i,
  output logic [1:0] colour_select_o,
  output logic projection_power_request_o
);
  initial colour_select_o = 2'h0;
  initial projection_power_request_o = 1'b0;
  always @(posedge clk_i) begin
    projection_power_request_o <= pwr_i;
    if (blank_i) begin
      colour_select_o <= 2'h0;
    end else if (step_i) begin
      colour_select_o <= (colour_select_o == 2'h3) ? 2'h1 : colour_select_o + 2'h1;
    end
  end
endmodule : rgbs_ctrl_model

// File: test_rgb_strobe_power_sequencer.sv
`timescale 1ns/1ps
module test_rgb_strobe_power_sequencer;
  import rgbs_pkg::*;
  logic clk = 0, rstn = 0, step = 0, blank = 0, pwr = 0, sck = 0, csn = 1, din = 0;
  logic [2:0] fault = 3'h0;
  logic [1:0] sel;
  logic req, dout, oe, led, s1, s2, s3, vld, irq;
  rails_s rails;
  logic [9:0] code;
  logic [9:0] codes [3];
  logic [7:0] rd;
  int err_count = 0, n_checks = 0, seed = 32'hf3d4, n;
  always #2 clk = ~clk;
  rgbs_ctrl_model rgbs_ctrl_model_inst (.clk_i(clk), .step_i(step), .blank_i(blank),
    .pwr_i(pwr), .colour_select_o(sel), .projection_power_request_o(req));
  rgb_strobe_power_sequencer #(.OFS_DELAY_CYC(20), .BIAS_DELAY_CYC(40), .PD_DELAY_CYC(10))
    rgb_strobe_power_sequencer_inst (.ref_clk_i(clk), .resetn_i(rstn),
    .projection_power_request_i(req), .colour_select_i(sel), .rail_fault_i(fault),
    .spi_clk_i(sck), .spi_cs_n_i(csn), .spi_din_i(din), .spi_dout_o(dout),
    .spi_dout_oe_o(oe), .mirror_init_o(), .rails_o(rails), .led_driver_enable_o(led),
    .first_channel_switch_o(s1), .second_channel_switch_o(s2),
    .third_channel_switch_o(s3), .current_code_o(code), .current_code_valid_o(vld),
    .interrupt_out_n_o(irq));
  task automatic tally_and_finish;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    n_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Sampling on the falling ref edge keeps reads clear of the update edge
  task automatic tick(input int k);
    repeat (k) @(negedge clk);
  endtask : tick
  task automatic spi(input logic [15:0] f);
    rd = 8'h00;
    @(posedge clk) csn <= 1'b0;
    for (int i = 15; i >= 0; i--) begin
      @(posedge clk) din <= f[i];
      tick(6);
      @(posedge clk) sck <= 1'b1;
      tick(6);
      if (i < 8) rd = {rd[6:0], dout};
      if (i == 0) chk("spi oe", 16'h1, oe);
      @(posedge clk) sck <= 1'b0;
    end
    tick(2);
    @(posedge clk) csn <= 1'b1;
    tick(8);
    chk("spi oe idle", 16'h0, oe);
  endtask : spi
  task automatic pulse_step;
    @(posedge clk) step <= 1'b1;
    @(posedge clk) step <= 1'b0;
  endtask : pulse_step
  task automatic power_up;
    @(posedge clk) pwr <= 1'b1;
    for (n = 0; n < 200 && led !== 1'b1; n++) tick(1);
  endtask : power_up
  function automatic logic [15:0] exp_sw(input logic [1:0] s);
    if (s == 2'h0) return 16'h0;
    return {3'h1, 3'(3'h1 << (s - 2'h1)), codes[s - 2'h1]};
  endfunction : exp_sw
  initial begin
    tick(2);
    @(posedge clk) rstn <= 1'b1;
    tick(2);
    chk("idle", 16'h1, {rails, led, s1, s2, s3, vld, irq});
    spi(16'h0b00); chk("dead", 16'h4, rd);
    spi(16'h0d00); chk("mask", 16'h0, rd);
    spi(16'hff5a); spi(16'h7f00); chk("unmapped", 16'h0, rd);
    for (int c = 0; c < 3; c++) begin
      codes[c] = (c == 2) ? 10'h3ff : 10'($random(seed));
      spi({1'b1, 7'(2 * c), codes[c][7:0]});
      spi({1'b1, 7'(2 * c + 1), 6'h0, codes[c][9:8]});
      spi({1'b0, 7'(2 * c), 8'h0}); chk("code", 16'(codes[c][7:0]), rd);
    end
    pulse_step(); tick(12);
    chk("gated", 16'h0, {s1, s2, s3, vld, led});
    @(posedge clk) blank <= 1'b1;
    @(posedge clk) blank <= 1'b0;
    power_up(); chk("rails up", 16'h7, rails);
    for (int i = 0; i < 7; i++) begin
      pulse_step(); tick(12 + ($random(seed) & 7));
      chk("strobe", exp_sw(sel), {vld, s3, s2, s1, vld ? code : 10'h0});
    end
    @(posedge clk) blank <= 1'b1;
    @(posedge clk) blank <= 1'b0;
    tick(12); chk("blank", 16'h0, {vld, s3, s2, s1});
    spi(16'h8807); spi(16'h0800); chk("ctrl", 16'h7, rd);
    spi(16'h8b08); pulse_step(); tick(16); pulse_step();
    for (n = 0; n < 20 && {s1, s2, s3} != 3'h0; n++) tick(1);
    for (n = 0; n < 30 && {s1, s2, s3} == 3'h0; n++) tick(1);
    chk("dead time", 16'h8, 16'(n));
    @(posedge clk) pwr <= 1'b0;
    tick(6); chk("bias off", 16'h4, rails);
    tick(20); chk("down", 16'h0, {rails, led});
    for (int m = 0; m < 2; m++) begin
      spi({8'h8d, m ? 8'h7 : 8'h0}); power_up();
      @(posedge clk) fault <= m ? 3'h1 : 3'h4;
      tick(6); chk("fault", 16'(m), {rails, irq});
      @(posedge clk) fault <= 3'h0;
      pwr <= 1'b0;
      tick(20); spi(16'h8e07); chk("irq clear", 16'h1, irq);
    end
    tally_and_finish();
  end
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    tally_and_finish();
  end
endmodule : test_rgb_strobe_power_sequencer
